// file: src/tlptx_pkg.sv
package tlptx_pkg;
    // ==========================================
    // Bus geometry
    localparam int DATA_W = 256;
    localparam int QW_W = 64;
    localparam int EMPTY_W = 2;
    localparam int RDY_LAT_DEF = 2;
    // ==========================================
    // Empty field encodings
    localparam logic [1:0] EMPTY_FULL = 2'h0;
    localparam logic [1:0] EMPTY_192 = 2'h1;
    localparam logic [1:0] EMPTY_128 = 2'h2;
    localparam logic [1:0] EMPTY_64 = 2'h3;
    // ==========================================
    // Reset and timing
    localparam int POST_RST_CYCLES = 2;
    localparam logic [1:0] RST_CNT_INIT = 2'h0;
    localparam logic [3:0] PKT_HDR_DW4 = 4'h4;
    // ==========================================
    // Packet tracking states
    typedef enum logic [1:0] {
        TLPTX_IDLE = 2'b00,
        TLPTX_BODY = 2'b01,
        TLPTX_HANG = 2'b11
    } tlptx_state_t;
endpackage

// file: src/tlptx_delay.sv
`timescale 1ns/10ps
// ==========================================
// Fixed-depth shift line for the ready pipeline
module tlptx_delay #(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic din, // Bit in
    output logic dout // Bit out, DEPTH cycles late
);
    logic [DEPTH-1:0] line_reg;

    // Depth one gets its own branch so the part-select never runs below zero
    generate
        if (DEPTH == 1) begin : g_one
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    line_reg <= '0;
                end else begin
                    line_reg[0] <= din;
                end
            end
        end else begin : g_many
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    line_reg <= '0;
                end else begin
                    line_reg <= {line_reg[DEPTH-2:0], din};
                end
            end
        end
    endgenerate

    assign dout = line_reg[DEPTH-1];
endmodule

// file: src/tlptx_sink.sv
`timescale 1ns/10ps
module tlptx_sink
    import tlptx_pkg::*;
#(
    parameter int READY_LATENCY = RDY_LAT_DEF,
    parameter int DATA_WIDTH = DATA_W
) (
    input wire logic sys_clk, // 25 MHz clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [DATA_WIDTH-1:0] transmit_payload_bus, // Beat data
    input wire logic packet_first_beat_marker, // First beat
    input wire logic packet_last_beat_marker, // Last beat
    input wire logic transmit_beat_qualifier, // Valid
    input wire logic [EMPTY_W-1:0] final_beat_unused_qwords, // Empty qwords
    input wire logic [15:0] expected_beats, // Beat count implied by header
    input wire logic sink_space_ok, // Downstream can take beats
    output logic transmit_accept_signal, // Ready
    output logic reset_status, // High while in reset or settling
    output logic [DATA_WIDTH-1:0] beat_data_out, // Captured beat, masked
    output logic beat_strobe_out, // One pulse per accepted beat
    output logic beat_first_out, // Captured beat opens a packet
    output logic beat_last_out, // Captured beat ends a packet
    output logic path_hung // Beat count mismatch seen
);
    // ==========================================
    // Limitations
    // Header fields are not parsed; the beat count arrives on its own port.
    // Ready latency is fixed at build time; the partner must match it.
    // Leaving a hang needs a full reset.
    // ==========================================
    // Reset status and ready generation
    logic [1:0] rst_cnt_reg;
    logic ready_cycle;
    tlptx_state_t state_reg;
    logic [15:0] beat_cnt_reg;
    logic [15:0] beat_goal_reg;
    logic take;

    // Ready may not rise until the settle time is over
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rst_cnt_reg <= RST_CNT_INIT;
            reset_status <= 1'b1;
        end else begin
            if (rst_cnt_reg != 2'(POST_RST_CYCLES)) begin
                rst_cnt_reg <= rst_cnt_reg + 2'h1;
            end
            reset_status <= (rst_cnt_reg != 2'(POST_RST_CYCLES - 1)) &&
                            (rst_cnt_reg != 2'(POST_RST_CYCLES));
        end
    end

    // Hang holds ready low until reset once the count is wrong
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            transmit_accept_signal <= 1'b0;
        end else begin
            transmit_accept_signal <= sink_space_ok && !reset_status &&
                                      (state_reg != TLPTX_HANG);
        end
    end

    // Ready cycle is the accept signal delayed by the latency
    tlptx_delay #(
        .DEPTH(READY_LATENCY)
    ) u_rdy_line (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din(transmit_accept_signal),
        .dout(ready_cycle)
    );

    assign take = transmit_beat_qualifier && ready_cycle;

    // ==========================================
    // Packet framing and beat count check
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= TLPTX_IDLE;
            beat_cnt_reg <= 16'h0000;
            beat_goal_reg <= 16'h0000;
        end else begin
            case (state_reg)
                TLPTX_IDLE: begin
                    if (take && packet_first_beat_marker) begin
                        beat_goal_reg <= expected_beats;
                        beat_cnt_reg <= 16'h0001;
                        if (packet_last_beat_marker) begin
                            if (expected_beats != 16'h0001) begin
                                state_reg <= TLPTX_HANG;
                            end
                        end else begin
                            state_reg <= TLPTX_BODY;
                        end
                    end
                end
                TLPTX_BODY: begin
                    if (take) begin
                        beat_cnt_reg <= beat_cnt_reg + 16'h0001;
                        if (packet_last_beat_marker) begin
                            if (beat_cnt_reg + 16'h0001 != beat_goal_reg) begin
                                state_reg <= TLPTX_HANG;
                            end else begin
                                state_reg <= TLPTX_IDLE;
                            end
                        end else if (beat_cnt_reg + 16'h0001 >= beat_goal_reg) begin
                            state_reg <= TLPTX_HANG;
                        end
                    end
                end
                TLPTX_HANG: begin
                    state_reg <= TLPTX_HANG;
                end
                default: begin
                    state_reg <= TLPTX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            path_hung <= 1'b0;
        end else begin
            path_hung <= (state_reg == TLPTX_HANG);
        end
    end

    // ==========================================
    // Beat capture with empty-qword masking
    function automatic logic [DATA_WIDTH-1:0] qw_mask(input logic [EMPTY_W-1:0] e);
        logic [DATA_WIDTH-1:0] m;
        m = '1;
        case (e)
            EMPTY_FULL: m = '1;
            EMPTY_192: m = {{QW_W{1'b0}}, {(DATA_WIDTH-QW_W){1'b1}}};
            EMPTY_128: m = {{(2*QW_W){1'b0}}, {(DATA_WIDTH-2*QW_W){1'b1}}};
            EMPTY_64: m = {{(3*QW_W){1'b0}}, {(DATA_WIDTH-3*QW_W){1'b1}}};
            default: m = '1;
        endcase
        return m;
    endfunction

    // ==========================================
    // Beat acceptance after the hang filter
    logic accept_beat;

    // A hung path drops every beat until reset
    assign accept_beat = take && (state_reg != TLPTX_HANG);

    // Strobe is high for one cycle per accepted beat, so back-to-back beats keep it high
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            beat_strobe_out <= 1'b0;
        end else begin
            beat_strobe_out <= accept_beat;
        end
    end

    // Markers hold until the next accepted beat
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            beat_first_out <= 1'b0;
        end else if (accept_beat) begin
            beat_first_out <= packet_first_beat_marker;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            beat_last_out <= 1'b0;
        end else if (accept_beat) begin
            beat_last_out <= packet_last_beat_marker;
        end
    end

    // Empty code only counts on the last beat; earlier beats pass whole
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            beat_data_out <= '0;
        end else if (accept_beat) begin
            if (packet_last_beat_marker) begin
                beat_data_out <= transmit_payload_bus &
                                 qw_mask(final_beat_unused_qwords);
            end else begin
                beat_data_out <= transmit_payload_bus;
            end
        end
    end
endmodule

// file: test/tlptx_sink_monitor.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the stream sink
module tlptx_sink_monitor
    import tlptx_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [DATA_W-1:0] transmit_payload_bus, // Data
    input wire logic packet_first_beat_marker, // First
    input wire logic packet_last_beat_marker, // Last
    input wire logic transmit_beat_qualifier, // Valid
    input wire logic [EMPTY_W-1:0] final_beat_unused_qwords, // Empty
    input wire logic transmit_accept_signal, // Ready
    input wire logic reset_status, // Status
    input wire logic [DATA_W-1:0] beat_data_out, // Beat
    input wire logic beat_strobe_out, // Strobe
    input wire logic beat_first_out, // First out
    input wire logic beat_last_out, // Last out
    input wire logic path_hung // Hung
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
AST_RST: assert property (disable iff (1'b0) !rst_n |=>
    !transmit_accept_signal && reset_status && !path_hung) else $error("Bad reset outputs");
AST_TAKE: assert property (transmit_beat_qualifier && $past(transmit_accept_signal, 2)
    |=> beat_strobe_out || path_hung) else $error("Beat in ready cycle lost");
AST_IDLE: assert property (!transmit_beat_qualifier |=> !beat_strobe_out)
    else $error("Beat taken without valid");
AST_FIRST: assert property (beat_strobe_out |->
    beat_first_out == $past(packet_first_beat_marker)) else $error("First marker wrong");
AST_LAST: assert property (beat_strobe_out |->
    beat_last_out == $past(packet_last_beat_marker)) else $error("Last marker wrong");
AST_DATA: assert property (beat_strobe_out && !beat_last_out
    |-> beat_data_out == $past(transmit_payload_bus)) else $error("Beat data wrong");
AST_MASK: assert property (beat_strobe_out && beat_last_out |->
    (beat_data_out >> (QW_W * (4 - $past(final_beat_unused_qwords)))) == '0)
    else $error("Unused qwords not cleared");
AST_HANG: assert property (path_hung |=> path_hung && !transmit_accept_signal)
    else $error("Hang not held");
endmodule

// file: test/tlptx_app_model.sv
`timescale 1ns/10ps
// ==========================================
// Application side, one packet per go pulse
module tlptx_app_model
    import tlptx_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic go, // Start
    input wire logic [3:0] n_beats, // Length
    input wire logic [1:0] empty_in, // Final empty
    input wire logic ready, // Accept
    output logic [DATA_W-1:0] data = '0, // Payload
    output logic first = 1'b0, // First
    output logic last = 1'b0, // Last
    output logic valid = 1'b0, // Valid
    output logic [1:0] empty = 2'h0, // Empty
    output logic busy // Beats left
);
logic [1:0] rdy_sh = 2'h0;
logic [3:0] idx = 4'h0;
logic [3:0] left = 4'h0;
logic go_q = 1'b0;
// Start is caught on the rising edge so the falling-edge driver never races it
always @(posedge sys_clk) go_q <= go;
assign busy = left != 4'h0;
always @(negedge sys_clk) begin
    rdy_sh <= {rdy_sh[0], ready};
    if (rdy_sh[1] && busy) begin
        valid <= 1'b1;
        first <= idx == 4'h0;
        last <= left == 4'h1;
        empty <= empty_in;
        data <= {64{idx + 4'h1}};
        idx <= idx + 4'h1;
        left <= left - 4'h1;
    end else begin
        valid <= 1'b0;
        first <= 1'b1; // Noise while idle
        last <= 1'b1;
        empty <= ~empty;
        data <= ~data;
    end
    if (go_q || !rst_n) begin
        idx <= 4'h0;
        left <= rst_n ? n_beats : 4'h0;
    end
end
endmodule

// file: test/tb_tlptx_sink.sv
`timescale 1ns/10ps
module tb_tlptx_sink;
import tlptx_pkg::*;
logic sys_clk = 1'b0;
logic rst_n = 1'b0;
logic go = 1'b0;
logic space = 1'b1;
logic [3:0] nb = 4'h1;
logic [1:0] em = 2'h0;
logic [1:0] empt;
logic [15:0] goal = 16'h0001;
logic [DATA_W-1:0] data, bdata, last_data;
logic first, last, valid, ready, busy, rst_stat, bstb, bfirst, blast, hung;
int n_mismatch = 0;
int n_tests = 0;
int n_beat = 0;
int cyc = 0;
tlptx_app_model i_app (.sys_clk, .rst_n, .go, .n_beats(nb), .empty_in(em), .ready, .data,
    .first, .last, .valid, .empty(empt), .busy);
tlptx_sink i_dut (.sys_clk, .rst_n, .transmit_payload_bus(data), .packet_first_beat_marker(first),
    .packet_last_beat_marker(last), .transmit_beat_qualifier(valid), .final_beat_unused_qwords(empt),
    .expected_beats(goal), .sink_space_ok(space), .transmit_accept_signal(ready),
    .reset_status(rst_stat), .beat_data_out(bdata), .beat_strobe_out(bstb),
    .beat_first_out(bfirst), .beat_last_out(blast), .path_hung(hung));
task automatic check(logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(ready, 1'b0);
    check(rst_stat, 1'b1);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(rst_stat, 1'b0);
    $display("reset test done");
endtask
task send(logic [3:0] n, logic [1:0] e, logic [15:0] g, bit bp);
    @(negedge sys_clk);
    nb = n;
    em = e;
    goal = g;
    go = 1'b1;
    n_beat = 0;
    @(negedge sys_clk);
    go = 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < 40 && busy; i++) begin
        if (bp && i == 3) space = 1'b0;
        if (i == 7) space = 1'b1;
        @(negedge sys_clk);
    end
    repeat (3) @(negedge sys_clk);
endtask
task t_empty();
    for (int e = 0; e < 4; e++) begin
        send(4'h2, 2'(e), 16'h0002, 1'b0);
        check(n_beat, 2);
        check(last_data, {64{4'h2}} & ({DATA_W{1'b1}} >> (QW_W * e)));
    end
    $display("empty code test done");
endtask
task t_backp();
    send(4'h6, EMPTY_FULL, 16'h0006, 1'b1);
    check(n_beat, 6);
    check(last_data, {64{4'h6}});
    check(hung, 1'b0);
    $display("backpressure test done");
endtask
task t_hang();
    send(4'h1, EMPTY_64, 16'h0002, 1'b0);
    check(hung, 1'b1);
    send(4'h1, EMPTY_64, 16'h0001, 1'b0);
    check(n_beat, 0);
    do_reset();
    check(hung, 1'b0);
    $display("hang test done");
endtask
always @(negedge sys_clk) begin
    cyc++;
    if (bstb === 1'b1) n_beat++;
    if (bstb === 1'b1 && blast === 1'b1) last_data = bdata;
    if (cyc == 3000) begin
        n_mismatch++;
        end_of_test();
    end
end
initial forever #20 sys_clk = ~sys_clk;
initial begin
    do_reset();
    t_empty();
    t_backp();
    t_hang();
    end_of_test();
end
endmodule
bind tlptx_sink tlptx_sink_monitor i_mon (.*);
